// *** shared/pubkey_irq_map.svh ***
// What this block does
// (R01) Enable bit 0 passes the job-done flag onto the interrupt request when 1 and masks it when 0.
// (R02) Enable bit 2 passes the memory-conflict flag onto the interrupt request when 1 and masks it when 0.
// (R03) Enable bit 3 passes the bad-address flag onto the interrupt request when 1 and masks it when 0.
// (R04) The enable register is a read-write word at offset 0x08 whose every bit clears to 0 on reset.
// (R05) Software writes the reserved enable bit positions only with zero.
// (R06) The job-done flag sets when the ready indication rises.
// (R07) Writing 1 to a status flag clears it, writing 0 does nothing, and software writes the bit back to 0.
// (R08) The memory-conflict flag sets on a bus access to the accelerator RAM while a job is running.
// (R09) The bad-address flag sets on a bus access to the accelerator RAM in an unmapped range.
// (R10) The interrupt request is high while any flag is set with its enable bit at 1, low otherwise.
`ifndef PUBKEY_IRQ_MAP_SVH
`define PUBKEY_IRQ_MAP_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define PKI_OFF_STAT 12'h004
`define PKI_OFF_ENMASK 12'h008
`define PKI_ENMASK_RST 32'h0000_0000
`define PKI_EN_STORE_RST 3'b000
`define PKI_EN_USED_MASK 32'h0000_000d
`define PKI_STAT_RST 1'b0
`define PKI_READY_RST 1'b1
`define PKI_RDATA_RST 32'h0000_0000
`define PKI_WADDR_RST 12'h000
`define PKI_READYOUT_RST 1'b1
`define PKI_IRQ_RST 1'b0

// ----------------------------------------
// Field positions shared by status and enable
// ----------------------------------------
`define PKI_BIT_DONE 0
`define PKI_BIT_MEMCF 2
`define PKI_BIT_BADADR 3
`define PKI_NUM_SRC 3

// ----------------------------------------
// Bus encodings
// ----------------------------------------
`define PKI_HSIZE_WORD 3'h2
`define PKI_HRESP_OKAY 1'b0
`define PKI_HRESP_ERROR 1'b1

`endif

// *** shared/pubkey_irq_pkg.sv ***
package pubkey_irq_pkg;

    // Bus access seen by the accelerator RAM, one-cycle pulse
    typedef struct packed {
        logic valid;
        logic unmapped;
    } ram_access_t;

    // Address phase of the register slave
    typedef struct packed {
        logic        sel;
        logic [1:0]  trans;
        logic        write;
        logic [2:0]  size;
        logic [11:0] addr;
        logic        ready;
    } ahb_req_t;

    // Slave answer
    typedef struct packed {
        logic [31:0] rdata;
        logic        readyout;
        logic        resp;
    } ahb_rsp_t;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'b0001,
        BUS_WRITE = 4'b0010,
        BUS_ERR1 = 4'b0100,
        BUS_ERR2 = 4'b1000
    } bus_state_t;

endpackage

// *** verilog/irq_flag_cell.sv ***
// ----------------------------------------
// Sticky event flag, set beats clear
// ----------------------------------------
module irq_flag_cell (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_set,
    input wire logic i_clr,
    output logic o_flag
);
    `include "pubkey_irq_map.svh"

    logic flag_reg;
    logic flag_next;

    // An event in the clearing cycle must survive
    // (R07) write one clears
    always_comb begin
        flag_next = flag_reg;
        if (i_set) begin
            flag_next = 1'b1;
        end else if (i_clr) begin
            flag_next = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flag_reg <= `PKI_STAT_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign o_flag = flag_reg;
endmodule

// *** verilog/pubkey_accel_irq_control.sv ***
// ----------------------------------------
// Interrupt status, enable and request
// ----------------------------------------
module pubkey_accel_irq_control (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire pubkey_irq_pkg::ahb_req_t i_ahb,
    input wire logic [31:0] i_hwdata,
    output pubkey_irq_pkg::ahb_rsp_t o_ahb,
    input wire logic i_job_ready,
    input wire pubkey_irq_pkg::ram_access_t i_ram_acc,
    output logic o_irq
);
    import pubkey_irq_pkg::*;
    `include "pubkey_irq_map.svh"

    localparam int unsigned SRC_BIT [`PKI_NUM_SRC] = '{
        `PKI_BIT_DONE, `PKI_BIT_MEMCF, `PKI_BIT_BADADR
    };

    bus_state_t state_reg;
    bus_state_t state_next;
    logic [11:0] waddr_reg;
    logic [11:0] waddr_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic readyout_reg;
    logic readyout_next;
    logic resp_reg;
    logic resp_next;
    logic [`PKI_NUM_SRC-1:0] en_reg;
    logic [`PKI_NUM_SRC-1:0] en_next;
    logic ready_prev_reg;
    logic ready_prev_next;
    logic irq_reg;
    logic irq_next;
    logic [`PKI_NUM_SRC-1:0] src_set;
    logic [`PKI_NUM_SRC-1:0] src_clr;
    logic [`PKI_NUM_SRC-1:0] flags;
    logic acc;
    logic wr_stat;
    logic wr_mask;
    logic [31:0] stat_word;
    logic [31:0] mask_word;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------

    // Only word accesses are legal; other sizes get the two-cycle error
    always_comb begin
        acc = i_ahb.sel && i_ahb.trans[1] && i_ahb.ready;
        state_next = state_reg;
        waddr_next = waddr_reg;
        rdata_next = rdata_reg;
        readyout_next = 1'b1;
        resp_next = `PKI_HRESP_OKAY;
        case (state_reg)
            BUS_ERR1: begin
                state_next = BUS_ERR2;
                resp_next = `PKI_HRESP_ERROR;
            end
            BUS_IDLE, BUS_WRITE, BUS_ERR2: begin
                state_next = BUS_IDLE;
                if (acc && i_ahb.size != `PKI_HSIZE_WORD) begin
                    state_next = BUS_ERR1;
                    readyout_next = 1'b0;
                    resp_next = `PKI_HRESP_ERROR;
                end else if (acc && i_ahb.write) begin
                    state_next = BUS_WRITE;
                    waddr_next = i_ahb.addr;
                end else if (acc) begin
                    // Unmapped offsets read as zero
                    case (i_ahb.addr)
                        `PKI_OFF_STAT: rdata_next = stat_word;
                        `PKI_OFF_ENMASK: rdata_next = mask_word;
                        default: rdata_next = `PKI_RDATA_RST;
                    endcase
                end
            end
            default: begin
                state_next = BUS_IDLE;
            end
        endcase
    end

    // Write strobes fire in the data phase, when hwdata is valid
    assign wr_stat = (state_reg == BUS_WRITE) && (waddr_reg == `PKI_OFF_STAT);
    assign wr_mask = (state_reg == BUS_WRITE) && (waddr_reg == `PKI_OFF_ENMASK);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= BUS_IDLE;
            waddr_reg <= `PKI_WADDR_RST;
            rdata_reg <= `PKI_RDATA_RST;
            readyout_reg <= `PKI_READYOUT_RST;
            resp_reg <= `PKI_HRESP_OKAY;
        end else begin
            state_reg <= state_next;
            waddr_reg <= waddr_next;
            rdata_reg <= rdata_next;
            readyout_reg <= readyout_next;
            resp_reg <= resp_next;
        end
    end

    assign o_ahb.rdata = rdata_reg;
    assign o_ahb.readyout = readyout_reg;
    assign o_ahb.resp = resp_reg;

    // ----------------------------------------
    // Event detection and flags
    // ----------------------------------------

    // Ready input comes from same-clock logic; history starts at its reset value
    always_comb begin
        ready_prev_next = i_job_ready;
        // (R06) ready rising edge
        src_set[0] = i_job_ready && !ready_prev_reg;
        // (R08) access while busy
        src_set[1] = i_ram_acc.valid && !i_job_ready;
        // (R09) unmapped RAM access
        src_set[2] = i_ram_acc.valid && i_ram_acc.unmapped;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ready_prev_reg <= `PKI_READY_RST;
        end else begin
            ready_prev_reg <= ready_prev_next;
        end
    end

    // One flag cell and one enable bit per source
    genvar gi;
    generate
        for (gi = 0; gi < `PKI_NUM_SRC; gi++) begin : g_src
            // (R07) write one clears
            assign src_clr[gi] = wr_stat && i_hwdata[SRC_BIT[gi]];
            irq_flag_cell u_flag (
                .i_ref_clk(i_ref_clk),
                .i_nrst(i_nrst),
                .i_set(src_set[gi]),
                .i_clr(src_clr[gi]),
                .o_flag(flags[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Enable register and request
    // ----------------------------------------

    // Reserved bits are not stored, so they read zero whatever is written
    always_comb begin
        en_next = en_reg;
        stat_word = `PKI_RDATA_RST;
        mask_word = `PKI_ENMASK_RST;
        for (int i = 0; i < `PKI_NUM_SRC; i++) begin
            // (R01) (R02) (R03) enable bit store
            if (wr_mask) begin
                en_next[i] = i_hwdata[SRC_BIT[i]];
            end
            stat_word[SRC_BIT[i]] = flags[i];
            mask_word[SRC_BIT[i]] = en_reg[i];
        end
        // (R10) level request
        irq_next = |(flags & en_reg);
    end

    // (R04) enables clear on reset
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            en_reg <= `PKI_EN_STORE_RST;
            irq_reg <= `PKI_IRQ_RST;
        end else begin
            en_reg <= en_next;
            irq_reg <= irq_next;
        end
    end

    assign o_irq = irq_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_done_gate;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        flags[0] && en_reg[0] |=> o_irq;
    endproperty
    a_done_gate: assert property (p_done_gate) else $error("done flag not passed"); // (R01)

    property p_memcf_gate;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        flags[1] && en_reg[1] |=> o_irq;
    endproperty
    a_memcf_gate: assert property (p_memcf_gate) else $error("conflict not passed"); // (R02)

    property p_badadr_gate;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        flags[2] && en_reg[2] |=> o_irq;
    endproperty
    a_badadr_gate: assert property (p_badadr_gate) else $error("bad addr not passed"); // (R03)

    // Reserved bits must read back zero whatever was written
    property p_mask_write;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        wr_mask |=> mask_word == ($past(i_hwdata) & `PKI_EN_USED_MASK);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("enable write lost"); // (R04)

    property p_ready_rise;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        $rose(i_job_ready) |-> ##1 flags[0];
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("done flag not set"); // (R06)

    property p_clear;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        src_clr[0] && !src_set[0] |=> !flags[0] && stat_word[`PKI_BIT_DONE] == 1'b0;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared"); // (R07)

    // Request follows the enable that stood while the flag was first seen
    property p_conflict;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_ram_acc.valid && !i_job_ready |=> flags[1] ##1 (o_irq || !$past(en_reg[1]));
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict not flagged"); // (R08)

    property p_badadr;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_ram_acc.valid && i_ram_acc.unmapped |=> flags[2];
    endproperty
    a_badadr: assert property (p_badadr) else $error("bad addr not flagged"); // (R09)

    property p_irq_low;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !(|(flags & en_reg)) |=> !o_irq;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("request without cause"); // (R10)
endmodule

// *** sim/cpu_bus_model.sv ***
// ----------------------------------------
// Processor side of the register bus
// ----------------------------------------
module cpu_bus_model (
    input wire logic i_ref_clk,
    input wire pubkey_irq_pkg::ahb_rsp_t i_ahb,
    output pubkey_irq_pkg::ahb_req_t o_ahb,
    output logic [31:0] o_hwdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import pubkey_irq_pkg::*;
    logic sel_reg = 1'b0;
    logic write_reg = 1'b0;
    logic [2:0] size_reg = 3'h2;
    logic [11:0] addr_reg = 12'h000;
    // Wait states of the last access, and accesses that never got ready
    int waits = 0;
    int stall_count = 0;
    // Sole master, so the bus-wide ready is the slave's own answer
    assign o_ahb = '{sel: sel_reg, trans: {sel_reg, 1'b0}, write: write_reg,
                     size: size_reg, addr: addr_reg, ready: i_ahb.readyout};
    initial o_hwdata = 32'h0000_0000;

    // One non-pipelined access; wait state bounded so a stuck slave cannot hang us
    task automatic xfer(input logic wr, input logic [2:0] sz, input logic [11:0] adr,
                        input logic [31:0] wd, output logic [31:0] rd, output logic rsp);
        int n;
        @(posedge i_ref_clk);
        sel_reg <= 1'b1;
        write_reg <= wr;
        size_reg <= sz;
        addr_reg <= adr;
        @(posedge i_ref_clk);
        sel_reg <= 1'b0;
        o_hwdata <= wd;
        n = 0;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (i_ahb.readyout !== 1'b1 && n < 8);
        waits = n - 1;
        // A stuck slave is counted as a mismatch at the close
        if (i_ahb.readyout !== 1'b1) begin
            stall_count++;
        end
        rd = i_ahb.rdata;
        rsp = i_ahb.resp;
    endtask

    task automatic set_enable(input logic [31:0] val);
        logic [31:0] rd;
        logic rsp;
        xfer(1'b1, 3'h2, 12'h008, val & 32'h0000_000d, rd, rsp);
    endtask

    task automatic clear_flags(input logic [31:0] m);
        logic [31:0] rd;
        logic rsp;
        xfer(1'b1, 3'h2, 12'h004, m & 32'h0000_000d, rd, rsp);
        xfer(1'b1, 3'h2, 12'h004, 32'h0000_0000, rd, rsp);
    endtask
endmodule

// *** sim/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import pubkey_irq_pkg::*;
    logic i_ref_clk;
    logic i_nrst;
    ahb_req_t bus_req;
    ahb_rsp_t bus_rsp;
    logic [31:0] hwdata;
    logic job_ready;
    ram_access_t ram_acc;
    logic irq;
    int num_errors = 0;
    int cmp_count = 0;
    int m_en;
    int m_flags;
    logic m_rdy;
    logic [31:0] rd;
    logic rsp;

    pubkey_accel_irq_control DUT (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ahb(bus_req),
        .i_hwdata(hwdata), .o_ahb(bus_rsp), .i_job_ready(job_ready), .i_ram_acc(ram_acc),
        .o_irq(irq));
    cpu_bus_model u_cpu (.i_ref_clk(i_ref_clk), .i_ahb(bus_rsp), .o_ahb(bus_req),
        .o_hwdata(hwdata));

    // 125 MHz clock
    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    // ----------------------------------------
    // Compare and report
    // ----------------------------------------
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic close_out();
        num_errors += u_cpu.stall_count;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Stimulus helpers and reference model
    // ----------------------------------------
    task automatic rd_chk(input string what, input logic [11:0] adr, input int exp);
        u_cpu.xfer(1'b0, 3'h2, adr, 32'h0000_0000, rd, rsp);
        chk_word(what, exp[31:0], rd);
        chk_bit("okay response", 1'b0, rsp);
        chk_word("read wait states", 32'h0000_0000, u_cpu.waits);
    endtask

    // Event lasts one cycle on the RAM strobe; the ready level is held afterwards
    task automatic fire(input logic r, input logic v, input logic u);
        @(posedge i_ref_clk);
        job_ready <= r;
        ram_acc <= '{valid: v, unmapped: u};
        if (r && !m_rdy) m_flags |= 1;
        if (v && !r) m_flags |= 4;
        if (v && u) m_flags |= 8;
        m_rdy = r;
        @(posedge i_ref_clk);
        ram_acc <= '0;
    endtask

    task automatic check_all();
        rd_chk("status word", 12'h004, m_flags);
        rd_chk("enable word", 12'h008, m_en);
        @(negedge i_ref_clk);
        chk_bit("irq", (m_flags & m_en) != 0, irq);
    endtask

    task automatic enable(input int v);
        u_cpu.set_enable(v);
        m_en = v & 32'hd;
    endtask

    task automatic clear(input int m);
        u_cpu.clear_flags(m);
        m_flags &= ~m;
    endtask

    // Budget: under 2000 cycles expected, ten times over
    initial begin
        #(20000 * 8);
        num_errors++;
        close_out();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        i_nrst = 1'b0;
        job_ready = 1'b1;
        ram_acc = '0;
        m_en = 0;
        m_flags = 0;
        m_rdy = 1'b1;
        void'($urandom(64));
        repeat (5) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        check_all();
        rd_chk("offset 0", 12'h000, 0);
        u_cpu.xfer(1'b1, 3'h2, 12'h00c, 32'h0000_000d, rd, rsp);
        rd_chk("offset c", 12'h00c, 0);
        u_cpu.xfer(1'b1, 3'h0, 12'h008, 32'h0000_000d, rd, rsp);
        chk_bit("error response", 1'b1, rsp);
        // Two-cycle error: one cycle with ready low before the final one
        chk_word("error wait states", 32'h0000_0001, u_cpu.waits);
        check_all();
        $display("test reset and map done");
        // Each source with its enable off, then on
        for (int k = 0; k < 4; k++) begin
            if (k == 1) continue;
            for (int e = 0; e < 2; e++) begin
                enable(e << k);
                if (k == 3) fire(1'b1, 1'b1, 1'b1);
                else fire(1'b0, k == 2, 1'b0);
                fire(1'b1, 1'b0, 1'b0);
                check_all();
                clear(1 << k);
                check_all();
            end
        end
        clear(13);
        $display("test per source done");
        for (int i = 0; i < 60; i++) begin
            fire($urandom % 2, $urandom % 2, $urandom % 2);
            if ($urandom % 3 == 0) enable($urandom);
            if ($urandom % 3 == 0) clear($urandom & 13);
            check_all();
        end
        $display("test random traffic done");
        close_out();
    end
endmodule
